// ==== rtl/ctp_pwm12.sv ====
`timescale 1ns/1ps
`include "ctp_params.svh"
module ctp_pwm12
   import ctp_pkg::*;
#(
   parameter int PRE_W = 11
) (
   core_clk,
   srst,
   ce,
   ext_count_pin,
   bus_addr,
   bus_wdata,
   bus_we,
   bus_re,
   bus_rdata,
   pwm_out_pin,
   ovf_irq,
   grp_irq
);
   input wire logic core_clk;
   input wire logic srst;
   input wire logic ce;
   input wire logic ext_count_pin;
   input wire logic [7:0] bus_addr;
   input wire logic [7:0] bus_wdata;
   input wire logic bus_we;
   input wire logic bus_re;
   output logic [7:0] bus_rdata;
   output logic pwm_out_pin;
   output logic ovf_irq;
   output logic grp_irq;

   // software registers
   logic [7:0] mode_r; // upper mode register
   logic [2:0] ctrl_r; // cascade control register
   logic [7:0] dlo_r; // low duty register
   logic [7:0] dhi_r; // high duty register
   // compare path
   logic [11:0] cmp_r; // active combined compare value
   logic [11:0] dbuf_r; // double buffer
   logic [11:0] cmp_nxt;
   logic [11:0] dbuf_nxt;
   // counting state
   ctp_state_t st_r;
   ctp_state_t st_nxt;
   logic [7:0] cnt_r; // up counter low byte
   logic [7:0] cnt_nxt;
   logic [3:0] frm_r; // frame index, 0 is frame 1
   logic [3:0] frm_nxt;
   logic phase_r; // output inverted since match
   logic phase_nxt;
   // output flops
   logic pwm_r;
   logic pwm_nxt;
   logic ovf_r;
   logic grp_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // address decode
   logic wr_ctrl;
   logic wr_mode;
   logic wr_dlo;
   logic wr_dhi;
   // control fields
   logic cas_en;
   logic upper_run;
   logic pwm_mode;
   logic dbe;
   logic init_lvl;
   logic go;
   logic running;
   // compare and frame decode
   logic [7:0] duty;
   logic extra_on;
   logic [8:0] cmp9;
   logic hit;
   logic wrap;
   logic grp_wrap;
   logic [11:0] commit;
   logic db_hold;

   ctp_src_if sif();

   // frame selection for extra pulses, idx 0 is frame 1
   function automatic logic extra_frame(input logic [3:0] sel,
                                        input logic [3:0] idx);
      logic f0;
      logic f1;
      logic f2;
      logic f3;
      f0 = sel[0] && (idx == 4'h8); // frame 9
      f1 = sel[1] && (idx[2:0] == 3'h4); // frames 5, 13
      f2 = sel[2] && (idx[1:0] == 2'h2); // frames 3, 7, 11, 15
      f3 = sel[3] && idx[0]; // even frames
      return f0 | f1 | f2 | f3;
   endfunction

   // register decode
   assign wr_ctrl = bus_we && (bus_addr == `CTP_ADR_CTRL);
   assign wr_mode = bus_we && (bus_addr == `CTP_ADR_MODE);
   assign wr_dlo = bus_we && (bus_addr == `CTP_ADR_DLO);
   assign wr_dhi = bus_we && (bus_addr == `CTP_ADR_DHI);

   // field extraction
   assign cas_en = ctrl_r[`CTP_C_CAS];
   assign upper_run = ctrl_r[`CTP_C_URUN];
   assign pwm_mode =
      (mode_r[`CTP_M_TCM_HI:`CTP_M_TCM_LO] == `CTP_TCM_PWM12);
   assign dbe = mode_r[`CTP_M_DBE];
   assign init_lvl = mode_r[`CTP_M_INIT];
   // only the cascade bit, the upper run bit and upper settings matter here
   assign go = cas_en && pwm_mode && upper_run;
   assign running = (st_r == CTP_ST_RUN);

   // count source selection
   assign sif.ext_sel = mode_r[`CTP_M_EXT];
   assign sif.div_sel = mode_r[`CTP_M_DIV_HI:`CTP_M_DIV_LO];
   assign sif.run = running;

   // duty is high register's low nibble over low register's high nibble
   assign duty = {cmp_r[11:8], cmp_r[7:4]};
   // zero select bits give no frame at all
   assign extra_on = extra_frame(cmp_r[3:0], frm_r);
   // stretched frames invert one count later
   assign cmp9 = {1'b0, duty} + {8'h00, extra_on};
   // match on the count being entered, so the pin turns with the counter
   assign hit = running && ({1'b0, cnt_nxt} == cmp9);
   assign wrap = running && sif.tick && (cnt_r == `CTP_CNT_TOP);
   assign grp_wrap = wrap && (frm_r == `CTP_FRM_LAST);

   // low register in 7:0, high low nibble in 11:8
   assign commit = {bus_wdata[3:0], dlo_r};
   assign db_hold = dbe && running;

   // commit on high write; buffer feeds compare at group end
   assign dbuf_nxt = wr_dhi ? commit : dbuf_r;
   assign cmp_nxt = (wr_dhi && !db_hold) ? commit :
                    (grp_wrap && dbe) ? dbuf_r : cmp_r;

   // run state: leaving run clears count and frame
   assign st_nxt = go ? CTP_ST_RUN : CTP_ST_IDLE;
   assign cnt_nxt = !running ? `CTP_CNT_ZERO :
                    sif.tick ? cnt_r + 8'h01 : cnt_r;
   assign frm_nxt = !running ? `CTP_FRM_FIRST :
                    wrap ? frm_r + 4'h1 : frm_r;

   // overflow clears the inversion, a match sets it
   assign phase_nxt = (!running || wrap) ? 1'b0 : (phase_r | hit);
   // pin level is the initial level unless inverted
   assign pwm_nxt = init_lvl ^ phase_nxt;

   // read multiplexer, unmapped reads give zero
   assign rdata_nxt =
      !bus_re ? 8'h00 :
      (bus_addr == `CTP_ADR_CTRL) ? {5'h00, ctrl_r} :
      (bus_addr == `CTP_ADR_MODE) ? mode_r :
      (bus_addr == `CTP_ADR_STAT) ? {2'h0, running, pwm_r, frm_r} :
      (bus_addr == `CTP_ADR_CNT) ? cnt_r :
      (bus_addr == `CTP_ADR_DLO) ? dlo_r :
      (bus_addr == `CTP_ADR_DHI) ? dhi_r : 8'h00;

   // count source
   ctp_clk_src #(
      .PRE_W(PRE_W)
   ) u_src (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .ext_count_pin(ext_count_pin),
      .src(sif.src)
   );

   // control register, lower run bit only stored
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_r <= `CTP_CTRL_RST;
      end else if (ce && wr_ctrl) begin
         ctrl_r <= bus_wdata[2:0];
      end
   end

   // mode register, frozen once the upper run bit is set
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mode_r <= `CTP_MODE_RST;
      end else if (ce && wr_mode && !upper_run) begin
         mode_r <= bus_wdata;
      end
   end

   // duty registers keep every written bit
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dlo_r <= `CTP_DUTY_RST;
         dhi_r <= `CTP_DUTY_RST;
      end else if (ce) begin
         if (wr_dlo) begin
            dlo_r <= bus_wdata;
         end
         if (wr_dhi) begin
            dhi_r <= bus_wdata;
         end
      end
   end

   // compare value and its buffer
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmp_r <= `CTP_CMP_RST;
         dbuf_r <= `CTP_CMP_RST;
      end else if (ce) begin
         cmp_r <= cmp_nxt;
         dbuf_r <= dbuf_nxt;
      end
   end

   // counting state
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_r <= CTP_ST_IDLE;
         cnt_r <= `CTP_CNT_ZERO;
         frm_r <= `CTP_FRM_FIRST;
         phase_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         frm_r <= frm_nxt;
         phase_r <= phase_nxt;
      end
   end

   // output flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pwm_r <= 1'b0;
         ovf_r <= 1'b0;
         grp_r <= 1'b0;
         rdata_r <= 8'h00;
      end else if (ce) begin
         pwm_r <= pwm_nxt;
         ovf_r <= wrap;
         grp_r <= grp_wrap;
         rdata_r <= rdata_nxt;
      end
   end

   assign bus_rdata = rdata_r;
   assign pwm_out_pin = pwm_r;
   assign ovf_irq = ovf_r;
   assign grp_irq = grp_r;

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   // last count of a frame with a tick
   sequence s_wrap;
      ce && wrap;
   endsequence

   // last frame of a running group reaching its end
   sequence s_last_frame;
      ce && running && (frm_r == `CTP_FRM_LAST) ##0 s_wrap;
   endsequence

   chk_mode_lock_run: assert property (
      (ce && upper_run && wr_mode) |=> $stable(mode_r))
      else $error("mode changed while running");

   chk_stop_clears_out: assert property (
      (ce && running && !go) ##1 (ce && !go) |=> (cnt_r == `CTP_CNT_ZERO)
         && (pwm_out_pin == init_lvl) && !running)
      else $error("stop did not clear counter and pin");

   chk_overflow_pulse: assert property (
      s_wrap |=> ovf_irq && (cnt_r == `CTP_CNT_ZERO)
         && (pwm_out_pin == init_lvl))
      else $error("overflow handling wrong");

   chk_group_pulse: assert property (
      s_last_frame |=> grp_irq && ovf_irq && (frm_r == `CTP_FRM_FIRST))
      else $error("group pulse missing");

   chk_group_only_last: assert property (
      (grp_irq && $past(ce)) |-> $past(frm_r) == `CTP_FRM_LAST)
      else $error("group pulse on wrong frame");

   chk_commit_direct: assert property (
      (ce && wr_dhi && !db_hold) |=>
         cmp_r == {$past(bus_wdata[3:0]), $past(dlo_r)})
      else $error("high write did not commit");

   chk_dbuf_hold: assert property (
      (ce && wr_dhi && db_hold && !grp_wrap) |=> $stable(cmp_r))
      else $error("buffered write reached compare");

   chk_match_invert: assert property (
      (ce && hit && !wrap && !phase_r && go) |=>
         (pwm_out_pin == !init_lvl))
      else $error("match did not invert pin");

   chk_extra_delay: assert property (
      (ce && running && extra_on && !phase_r && !wrap && (cnt_nxt == duty))
         |=> pwm_out_pin == init_lvl)
      else $error("extra frame not delayed");

   chk_stop_level: assert property (
      (ce && !running && !go) |=> pwm_out_pin == $past(init_lvl))
      else $error("stopped pin not at initial level");
endmodule

// ==== pkg/ctp_params.svh ====
`ifndef CTP_PARAMS_SVH
`define CTP_PARAMS_SVH

// register offsets on the plain register port
`define CTP_ADR_CTRL 8'h24
`define CTP_ADR_MODE 8'h25
`define CTP_ADR_STAT 8'h26
`define CTP_ADR_CNT 8'h27
`define CTP_ADR_DLO 8'h28
`define CTP_ADR_DHI 8'h29

// reset values
`define CTP_DUTY_RST 8'hFF
`define CTP_CMP_RST 12'hFFF
`define CTP_MODE_RST 8'h00
`define CTP_CTRL_RST 3'h0

// mode register fields
`define CTP_M_DBE 7
`define CTP_M_TCM_HI 6
`define CTP_M_TCM_LO 5
`define CTP_M_EXT 4
`define CTP_M_DIV_HI 3
`define CTP_M_DIV_LO 1
`define CTP_M_INIT 0
`define CTP_TCM_PWM12 2'h2

// control register fields
`define CTP_C_CAS 0
`define CTP_C_LRUN 1
`define CTP_C_URUN 2

// counter and frame limits
`define CTP_CNT_TOP 8'hFF
`define CTP_CNT_ZERO 8'h00
`define CTP_FRM_FIRST 4'h0
`define CTP_FRM_LAST 4'hF

// prescaler tap masks, one per divider code
`define CTP_DIV_M0 11'h7FF
`define CTP_DIV_M1 11'h3FF
`define CTP_DIV_M2 11'h0FF
`define CTP_DIV_M3 11'h03F
`define CTP_DIV_M4 11'h00F
`define CTP_DIV_M5 11'h003
`define CTP_DIV_M6 11'h001
`define CTP_DIV_M7 11'h000

`endif

// ==== pkg/ctp_pkg.sv ====
package ctp_pkg;
   // run state of the cascaded counter
   typedef enum logic [1:0] {
      CTP_ST_IDLE = 2'b01,
      CTP_ST_RUN = 2'b10
   } ctp_state_t;
   // divider code
   typedef logic [2:0] ctp_div_t;
endpackage

// ==== pkg/ctp_src_if.sv ====
`timescale 1ns/1ps
// source clock selection and count tick between control and source
interface ctp_src_if;
   import ctp_pkg::*;
   logic ext_sel; // count external pin edges
   ctp_div_t div_sel; // internal divider code
   logic run; // prescaler runs, else held clear
   logic tick; // one-cycle count pulse
   modport ctl(output ext_sel, output div_sel, output run, input tick);
   modport src(input ext_sel, input div_sel, input run, output tick);
endinterface

// ==== rtl/ctp_clk_src.sv ====
`timescale 1ns/1ps
`include "ctp_params.svh"
// count source: internal prescaler or synchronised external pin
module ctp_clk_src
   import ctp_pkg::*;
#(
   parameter int PRE_W = 11
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic ext_count_pin,
   ctp_src_if.src src
);
   logic [PRE_W-1:0] pre_r; // free prescaler
   logic [PRE_W-1:0] pre_nxt;
   logic [2:0] sync_r; // pin synchroniser, [0] first stage
   logic lvl_r; // accepted pin level, moves when stages two and three agree
   logic lvl_nxt;
   logic tick_r;
   logic [PRE_W-1:0] mask;
   logic int_tick;
   logic ext_fall;
   logic tick_nxt;

   // tap mask for a divider code
   function automatic logic [PRE_W-1:0] div_mask(input ctp_div_t d);
      logic [10:0] m;
      m = `CTP_DIV_M0;
      unique case (d)
         3'h0: m = `CTP_DIV_M0;
         3'h1: m = `CTP_DIV_M1;
         3'h2: m = `CTP_DIV_M2;
         3'h3: m = `CTP_DIV_M3;
         3'h4: m = `CTP_DIV_M4;
         3'h5: m = `CTP_DIV_M5;
         3'h6: m = `CTP_DIV_M6;
         3'h7: m = `CTP_DIV_M7;
      endcase
      return m[PRE_W-1:0];
   endfunction

   assign mask = div_mask(src.div_sel);
   assign int_tick = (pre_r & mask) == mask;
   // falling edge once second and third stage agree on the new level
   assign ext_fall = lvl_r & ~sync_r[2] & ~sync_r[1];
   // a one-cycle glitch between stages never moves the accepted level
   assign lvl_nxt = (sync_r[2] == sync_r[1]) ? sync_r[2] : lvl_r;
   // pin edges or prescaler taps select the source
   assign tick_nxt = src.run & (src.ext_sel ? ext_fall : int_tick);
   assign pre_nxt = src.run ? pre_r + 1'b1 : '0;
   assign src.tick = tick_r;

   // prescaler, synchroniser and tick register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pre_r <= '0;
         sync_r <= '1; // idle-high pin, so no false edge after reset
         lvl_r <= 1'b1;
         tick_r <= 1'b0;
      end else if (ce) begin
         pre_r <= pre_nxt;
         sync_r <= {sync_r[1:0], ext_count_pin};
         lvl_r <= lvl_nxt;
         tick_r <= tick_nxt;
      end
   end

   // a tick never follows an enabled cycle with the source held
   chk_src_hold: assert property (@(posedge core_clk) disable iff (srst)
      (ce && !src.run) |=> !tick_r)
      else $error("count tick while source held");
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
`include "ctp_params.svh"
// self-checking bench for the cascaded 12-bit pwm block
module tb;
   import ctp_pkg::*;
   logic core_clk = 1'b0; // 40 MHz bench clock
   logic srst = 1'b1; // synchronous reset, held at start
   logic ce = 1'b1; // clock enable, on except for one stretch of the main sequence
   logic ext_count_pin = 1'b1; // external count input, idles high
   logic [7:0] bus_addr = 8'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_we = 1'b0;
   logic bus_re = 1'b0;
   logic [7:0] bus_rdata;
   logic pwm_out_pin;
   logic ovf_irq;
   logic grp_irq;
   int n_mismatch = 0; // mismatches seen
   int checks = 0; // comparisons made
   logic [31:0] seed_r = 32'h0000FAA1; // xorshift state
   logic [7:0] rd_v; // last read value
   logic [7:0] sel_tab [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0F};

   // clock: half period 12.5 ns
   always #12.5 core_clk = ~core_clk;

   ctp_pwm12 dut (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .ext_count_pin(ext_count_pin),
      .bus_addr(bus_addr),
      .bus_wdata(bus_wdata),
      .bus_we(bus_we),
      .bus_re(bus_re),
      .bus_rdata(bus_rdata),
      .pwm_out_pin(pwm_out_pin),
      .ovf_irq(ovf_irq),
      .grp_irq(grp_irq)
   );

   // next xorshift value
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // whether frame f (1..16) gets the one-tick stretch
   function automatic logic extra_of(input logic [3:0] sel, input int f);
      return (sel[0] && f == 9) || (sel[1] && (f == 5 || f == 13))
         || (sel[2] && f % 4 == 3) || (sel[3] && f % 2 == 0);
   endfunction

   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask

   // print counts and verdict, then end the run
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_we <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge core_clk);
      bus_we <= 1'b0;
   endtask

   // one-cycle read, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus_re <= 1'b1;
      bus_addr <= a;
      @(posedge core_clk);
      bus_re <= 1'b0;
      #1;
      d = bus_rdata;
   endtask

   // read and compare
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a, rd_v);
      chk(rd_v, e);
   endtask

   // full 16-frame group with cycle-exact level counts per frame
   task automatic pwm_run(input logic [3:0] sel, input logic init,
                          input logic [7:0] ctl);
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] duty;
      logic [7:0] md;
      int cnt;
      int w;
      seed_r = xs(seed_r);
      lo = {seed_r[7:4], sel};
      hi = {seed_r[15:12], 4'(seed_r[19:16] % 14 + 1)};
      duty = {hi[3:0], lo[7:4]};
      md = {~init, `CTP_TCM_PWM12, 1'b0, 3'h7, init};
      wr(`CTP_ADR_MODE, md);
      wr(`CTP_ADR_DLO, lo);
      wr(`CTP_ADR_DHI, hi);
      wr(`CTP_ADR_DLO, ~lo); // low byte alone must not commit
      chk(pwm_out_pin, init);
      rdc(`CTP_ADR_DHI, hi);
      wr(`CTP_ADR_CTRL, ctl);
      wr(`CTP_ADR_MODE, ~md);
      rdc(`CTP_ADR_MODE, md);
      for (int f = 1; f <= 16; f++) begin
         w = 0;
         while (ovf_irq !== 1'b1 && w < 600) begin
            @(posedge core_clk);
            #1;
            w++;
         end
         chk(16'(w < 600), 16'h0001);
         chk(grp_irq, f == 16);
         // count initial-level samples across one 256-tick frame
         cnt = 0;
         for (int i = 0; i < 256; i++) begin
            if (i > 0) begin
               @(posedge core_clk);
               #1;
            end
            cnt += (pwm_out_pin === init);
         end
         chk(cnt, duty + extra_of(sel, f % 16 + 1));
      end
      // rewrite while running: buffered or direct by the enable bit
      wr(`CTP_ADR_DLO, lo ^ 8'h30);
      wr(`CTP_ADR_DHI, hi);
      rdc(`CTP_ADR_DLO, lo ^ 8'h30);
      wr(`CTP_ADR_CTRL, 8'h01);
      @(posedge core_clk); // state leaves run one edge after the write
      rdc(`CTP_ADR_CNT, 8'h00);
      chk(pwm_out_pin, init);
   endtask

   // watchdog: far beyond the expected run length
   initial begin
      repeat (80000) @(posedge core_clk);
      n_mismatch++;
      stop_test;
   end

   // main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      // reset values and an unmapped place
      rdc(`CTP_ADR_DLO, 8'hFF);
      rdc(`CTP_ADR_DHI, 8'hFF);
      rdc(`CTP_ADR_CTRL, 8'h00);
      rdc(`CTP_ADR_MODE, 8'h00);
      rdc(8'h30, 8'h00);
      rdc(`CTP_ADR_STAT, 8'h00);
      chk(pwm_out_pin, 1'b0);
      // no cascade: the counter must not move
      wr(`CTP_ADR_MODE, {1'b0, `CTP_TCM_PWM12, 1'b0, 3'h7, 1'b0});
      wr(`CTP_ADR_CTRL, 8'h04);
      repeat (20) @(posedge core_clk);
      rdc(`CTP_ADR_CNT, 8'h00);
      // wrong mode field: still no counting
      wr(`CTP_ADR_CTRL, 8'h00);
      wr(`CTP_ADR_MODE, 8'h2E);
      wr(`CTP_ADR_CTRL, 8'h05);
      repeat (20) @(posedge core_clk);
      rdc(`CTP_ADR_CNT, 8'h00);
      wr(`CTP_ADR_CTRL, 8'h00);
      // external source: ten slow falling edges
      wr(`CTP_ADR_MODE, {1'b0, `CTP_TCM_PWM12, 1'b1, 3'h0, 1'b0});
      wr(`CTP_ADR_CTRL, 8'h05);
      repeat (10) begin
         repeat (4) @(posedge core_clk);
         ext_count_pin <= 1'b0;
         repeat (4) @(posedge core_clk);
         ext_count_pin <= 1'b1;
      end
      repeat (8) @(posedge core_clk);
      rdc(`CTP_ADR_CNT, 8'h0A);
      rdc(`CTP_ADR_STAT, 8'h20);
      // clock enable low: strobes and pin edges are ignored
      ce <= 1'b0;
      wr(`CTP_ADR_DLO, 8'h5A);
      repeat (3) begin
         @(posedge core_clk);
         ext_count_pin <= 1'b0;
         repeat (3) @(posedge core_clk);
         ext_count_pin <= 1'b1;
      end
      repeat (4) @(posedge core_clk);
      ce <= 1'b1;
      rdc(`CTP_ADR_DLO, 8'hFF);
      repeat (8) @(posedge core_clk);
      rdc(`CTP_ADR_CNT, 8'h0A);
      wr(`CTP_ADR_CTRL, 8'h01);
      // pwm groups over six extra-pulse select patterns: none, each single bit, all four
      for (int k = 0; k < 6; k++) begin
         pwm_run(sel_tab[k][3:0], k[0], k[1] ? 8'h07 : 8'h05);
      end
      stop_test;
   end
endmodule
